// *** buck3_config_registers.sv ***
// buck3_config_registers: set point and configuration registers of the third buck regulator.
// assumes: the serial control port decodes transactions into one-cycle read and write
// strobes on this clock; the one-time-programmable range bit is valid while rst is high.
`timescale 1ns/100ps

// Behaviour
// - normal set point at 0x3C, bits 5:0 writable, reset zero.
// - normal bit 6 is the read-only range bit loaded from OTP.
// - standby set point at 0x3D, bits 5:0 writable, used in standby.
// - sleep set point at 0x3E, bits 5:0 writable, used in sleep.
// - standby bit 6 reads back the OTP range bit, read-only.
// - sleep bit 6 reads back the OTP range bit, read-only.
// - mode register at 0x3F, bits 3:0 mode selector, reset 0x08.
// - mode bit 5 picks sleep behaviour: 0 off, 1 pulse-frequency, reset zero.
// - config 0x40 bit 0 current limit: 0 high, 1 low, reset zero.
// - config bits 3:2 frequency selector; bit 1 spare but read/write.
// - config bits 5:4 phase clock selector, reset zero.
// - config bits 7:6 ramp speed selector, reset zero.
// - range 1: 0.800 V + 50 mV/step; range 0: codes from 9, 0.625 V + 25 mV.
module buck3_config_registers
  import buck3_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         otp_range,
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata,
  input  wire logic [1:0]   power_state,
  output logic              range_high,
  output logic      [5:0]   normal_code,
  output logic      [5:0]   standby_code,
  output logic      [5:0]   sleep_code,
  output logic      [3:0]   switching_mode,
  output logic              sleep_behaviour_select,
  output buck_ctrl_t        ctrl,
  output logic      [5:0]   active_code,
  output logic      [11:0]  active_mv,
  output logic              active_reserved,
  output logic              buck_enable
);

  // ==========================================================
  // decoding helpers
  function automatic logic [11:0] code_to_mv(input logic rng, input logic [5:0] code);
    logic [11:0] c;
    c = {6'h00, code};
    if (rng) begin
      code_to_mv = 12'(HI_BASE_MV + HI_STEP_MV * c);
    end else if (code < LO_MIN_CODE) begin
      code_to_mv = 12'h000;
    end else begin
      code_to_mv = 12'(LO_BASE_MV + LO_STEP_MV * (c - {6'h00, LO_MIN_CODE}));
    end
  endfunction

  function automatic logic code_reserved(input logic rng, input logic [5:0] code);
    code_reserved = rng ? (code > HI_MAX_CODE) : (code < LO_MIN_CODE);
  endfunction

  function automatic logic [7:0] setpoint_view(input logic rng, input logic [5:0] code);
    // bit 7 always zero, bit 6 always the loaded range
    setpoint_view = {1'b0, rng, code};
  endfunction

  // ==========================================================
  // state
  reg_req_t req;
  state_t   st_r;
  state_t   st_nxt;

  assign req = '{addr: reg_addr, wr: reg_wr, rd: reg_rd, wdata: reg_wdata};

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 8'h00;
    if (rst) begin
      st_nxt.normal_code  = CODE_RST;
      st_nxt.standby_code = CODE_RST;
      st_nxt.sleep_code   = CODE_RST;
      st_nxt.mode_sel     = MODE_RST;
      st_nxt.sleep_pfm    = 1'b0;
      st_nxt.config_q     = CONFIG_RST;
      // range is captured from otp only while held in reset, then frozen
      st_nxt.range        = otp_range;
    end else begin
      if (req.wr) begin
        case (req.addr)
          ADDR_NORMAL:  st_nxt.normal_code  = req.wdata[CODE_W-1:0];
          ADDR_STANDBY: st_nxt.standby_code = req.wdata[CODE_W-1:0];
          ADDR_SLEEP:   st_nxt.sleep_code   = req.wdata[CODE_W-1:0];
          ADDR_MODE: begin
            st_nxt.mode_sel  = req.wdata[MODE_W-1:0];
            st_nxt.sleep_pfm = req.wdata[SLEEP_PFM_BIT];
          end
          ADDR_CONFIG:  st_nxt.config_q     = req.wdata;
          default: ;
        endcase
      end
      if (req.rd) begin
        case (req.addr)
          ADDR_NORMAL:  st_nxt.rdata = setpoint_view(st_r.range, st_r.normal_code);
          ADDR_STANDBY: st_nxt.rdata = setpoint_view(st_r.range, st_r.standby_code);
          ADDR_SLEEP:   st_nxt.rdata = setpoint_view(st_r.range, st_r.sleep_code);
          ADDR_MODE:    st_nxt.rdata = {2'b00, st_r.sleep_pfm, 1'b0, st_r.mode_sel};
          ADDR_CONFIG:  st_nxt.rdata = st_r.config_q;
          default:      st_nxt.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // outputs to the regulator
  assign reg_rdata              = st_r.rdata;
  assign range_high             = st_r.range;
  assign normal_code            = st_r.normal_code;
  assign standby_code           = st_r.standby_code;
  assign sleep_code             = st_r.sleep_code;
  assign switching_mode         = st_r.mode_sel;
  assign sleep_behaviour_select = st_r.sleep_pfm;
  assign ctrl.current_limit_low          = st_r.config_q[ILIM_BIT];
  assign ctrl.cfg_spare                  = st_r.config_q[ILIM_BIT+1];
  assign ctrl.switching_frequency_select = st_r.config_q[FREQ_LSB+1:FREQ_LSB];
  assign ctrl.phase_clock_select         = st_r.config_q[PHASE_LSB+1:PHASE_LSB];
  assign ctrl.ramp_speed_select          = st_r.config_q[RAMP_LSB+1:RAMP_LSB];

  // set point follows the power state; an unknown state falls back to normal
  always_comb begin
    case (power_state)
      PWR_STANDBY: active_code = st_r.standby_code;
      PWR_SLEEP:   active_code = st_r.sleep_code;
      default:     active_code = st_r.normal_code;
    endcase
  end

  assign active_mv       = code_to_mv(st_r.range, active_code);
  assign active_reserved = code_reserved(st_r.range, active_code);
  // sleep with the off choice shuts the output down
  assign buck_enable = !(power_state == PWR_SLEEP && !st_r.sleep_pfm);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_write(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence

  a_normal_write: assert property (s_write(ADDR_NORMAL) |=>
      normal_code == $past(reg_wdata[5:0]))
    else $error("normal set point did not take write");

  a_range_frozen: assert property ($stable(range_high))
    else $error("range bit changed outside reset");

  a_standby_readback: assert property (
      s_write(ADDR_STANDBY) ##1 s_read(ADDR_STANDBY) |=>
      reg_rdata[5:0] == $past(reg_wdata[5:0], 2))
    else $error("standby write not read back");

  a_sleep_select: assert property (
      power_state == PWR_SLEEP |-> active_code == sleep_code)
    else $error("sleep set point not applied");

  a_standby_mirror: assert property (s_read(ADDR_STANDBY) |=>
      reg_rdata[7:6] == {1'b0, range_high})
    else $error("standby range bit not mirrored");

  a_sleep_mirror: assert property (
      s_write(ADDR_SLEEP) ##1 s_read(ADDR_SLEEP) |=> reg_rdata[6] == range_high)
    else $error("sleep range bit not mirrored");

  a_mode_readback: assert property (
      s_write(ADDR_MODE) ##1 s_read(ADDR_MODE) |=>
      reg_rdata == ($past(reg_wdata, 2) & MODE_MASK))
    else $error("mode register readback wrong");

  a_sleep_off: assert property (
      power_state == PWR_SLEEP && !sleep_behaviour_select |-> !buck_enable)
    else $error("buck not off in sleep");

  a_config_fields: assert property (s_write(ADDR_CONFIG) |=>
      {ctrl.ramp_speed_select, ctrl.phase_clock_select, ctrl.switching_frequency_select,
       ctrl.cfg_spare, ctrl.current_limit_low} == $past(reg_wdata))
    else $error("config fields do not follow write");

  a_high_range_mv: assert property (range_high && active_code == 6'h0A |->
      active_mv == 12'h514)
    else $error("high range coding wrong");

  a_low_range_mv: assert property (!range_high && active_code == 6'h3F |->
      active_mv == 12'h7B7)
    else $error("low range coding wrong");

  a_normal_unused: assert property (s_read(ADDR_NORMAL) |=>
      reg_rdata[7] == 1'b0 && reg_rdata[5:0] == $past(normal_code))
    else $error("normal set point readback wrong");

  // ==========================================================
  // reset, load and decode checks
  // reset is synchronous, so the first edge with rst low shows the reset values
  sequence s_reset_left;
    $fell(rst);
  endsequence

  a_reset_codes: assert property (s_reset_left |->
      normal_code == CODE_RST && standby_code == CODE_RST && sleep_code == CODE_RST)
    else $error("set point codes not cleared by reset");

  a_reset_mode: assert property (s_reset_left |->
      switching_mode == MODE_RST && !sleep_behaviour_select)
    else $error("mode register not at reset value");

  a_reset_config: assert property (s_reset_left |->
      {ctrl.ramp_speed_select, ctrl.phase_clock_select, ctrl.switching_frequency_select,
       ctrl.cfg_spare, ctrl.current_limit_low} == CONFIG_RST)
    else $error("config register not at reset value");

  a_range_load: assert property (s_reset_left |->
      range_high == $past(otp_range))
    else $error("range bit not loaded during reset");

  a_standby_write: assert property (s_write(ADDR_STANDBY) |=>
      standby_code == $past(reg_wdata[CODE_W-1:0]))
    else $error("standby set point did not take write");

  a_sleep_write: assert property (s_write(ADDR_SLEEP) |=>
      sleep_code == $past(reg_wdata[CODE_W-1:0]))
    else $error("sleep set point did not take write");

  a_mode_write: assert property (s_write(ADDR_MODE) |=>
      switching_mode == $past(reg_wdata[MODE_W-1:0]) &&
      sleep_behaviour_select == $past(reg_wdata[SLEEP_PFM_BIT]))
    else $error("mode register did not take write");

  a_normal_stray: assert property (reg_wr && reg_addr != ADDR_NORMAL |=>
      $stable(normal_code))
    else $error("normal set point changed by another write");

  a_standby_stray: assert property (reg_wr && reg_addr != ADDR_STANDBY |=>
      $stable(standby_code))
    else $error("standby set point changed by another write");

  a_sleep_stray: assert property (reg_wr && reg_addr != ADDR_SLEEP |=>
      $stable(sleep_code))
    else $error("sleep set point changed by another write");

  a_config_stray: assert property (reg_wr && reg_addr != ADDR_CONFIG |=>
      $stable(ctrl))
    else $error("config fields changed by another write");

  a_normal_range: assert property (s_read(ADDR_NORMAL) |=>
      reg_rdata[RANGE_BIT] == range_high)
    else $error("normal range bit not read back");

  a_sleep_readback: assert property (s_read(ADDR_SLEEP) |=>
      reg_rdata[CODE_W-1:0] == $past(sleep_code))
    else $error("sleep set point readback wrong");

  a_mode_unused: assert property (s_read(ADDR_MODE) |=>
      (reg_rdata & ~MODE_MASK) == 8'h00)
    else $error("unused mode bits not zero");

  a_config_readback: assert property (s_read(ADDR_CONFIG) |=>
      reg_rdata == $past({ctrl.ramp_speed_select, ctrl.phase_clock_select,
                          ctrl.switching_frequency_select, ctrl.cfg_spare,
                          ctrl.current_limit_low}))
    else $error("config register readback wrong");

  a_active_normal: assert property (
      power_state != PWR_STANDBY && power_state != PWR_SLEEP |-> active_code == normal_code)
    else $error("normal set point not applied");

  a_active_standby: assert property (
      power_state == PWR_STANDBY |-> active_code == standby_code)
    else $error("standby set point not applied");

  a_sleep_pfm: assert property (
      power_state == PWR_SLEEP && sleep_behaviour_select |-> buck_enable)
    else $error("buck not running in sleep with pulse-frequency choice");

  a_high_base: assert property (range_high && active_code == CODE_RST |->
      active_mv == HI_BASE_MV)
    else $error("high range base voltage wrong");

  a_low_first: assert property (!range_high && active_code == LO_MIN_CODE |->
      active_mv == LO_BASE_MV)
    else $error("first low range code wrong");

  a_low_reserved: assert property (!range_high && active_code < LO_MIN_CODE |->
      active_mv == 12'h000 && active_reserved)
    else $error("reserved low range code not flagged");

endmodule // buck3_config_registers

// *** buck3_config_registers_tb.sv ***
// buck3_config_registers_tb: self-checking bench for the buck3 register bank.
// assumes: buck3_pkg compiled first; host model drives the register port.
`timescale 1ns/100ps
module buck3_config_registers_tb;
  import buck3_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, otp_range = 1'b1, rd_taken = 1'b0, range_exp;
  logic [1:0]  power_state = 2'b00;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, range_high, sleep_behaviour_select, active_reserved, buck_enable;
  logic [5:0]  normal_code, standby_code, sleep_code, active_code;
  logic [3:0]  switching_mode;
  logic [11:0] active_mv;
  buck_ctrl_t  ctrl;
  logic [7:0]  exp_q[$];
  logic [7:0]  shadow [5];
  int          mismatches = 0, num_checks = 0, seed = 43826;

  always #5 clock = ~clock;

  buck3_host_model i_buck3_host_model (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  buck3_config_registers i_buck3_config_registers (.clock(clock), .rst(rst),
    .otp_range(otp_range), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_state(power_state),
    .range_high(range_high), .normal_code(normal_code), .standby_code(standby_code),
    .sleep_code(sleep_code), .switching_mode(switching_mode),
    .sleep_behaviour_select(sleep_behaviour_select), .ctrl(ctrl), .active_code(active_code),
    .active_mv(active_mv), .active_reserved(active_reserved), .buck_enable(buck_enable));

  // ==========================================================
  // checking
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // read data lives one cycle only, zero elsewhere
  always @(posedge clock) rd_taken <= reg_rd && !rst;
  always @(negedge clock) begin
    if (rd_taken) check(reg_rdata, exp_q.pop_front());
    else check(reg_rdata, 8'h00);
  end

  initial begin
    #50000;
    mismatches++;
    complete_run;
  end

  // ==========================================================
  // host operations and expectations
  task automatic do_reset(input logic r);
    @(posedge clock);
    otp_range <= r;
    rst       <= 1'b1;
    repeat (8) @(posedge clock);
    rst       <= 1'b0;
    otp_range <= !r;
    range_exp = r;
    shadow = '{{1'b0, r, 6'h00}, {1'b0, r, 6'h00}, {1'b0, r, 6'h00}, 8'h08, 8'h00};
  endtask

  task automatic note_write(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h3C && a <= 8'h3E) shadow[a - 8'h3C] = {1'b0, range_exp, d[5:0]};
    else if (a == 8'h3F) shadow[3] = d & 8'h2F;
    else if (a == 8'h40) shadow[4] = d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_buck3_host_model.xfer(1'b1, a, d);
    note_write(a, d);
  endtask

  // back-to-back write and read of a mapped register
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    note_write(a, d);
    exp_q.push_back(shadow[a - 8'h3C]);
    i_buck3_host_model.xfer_wr_rd(a, d);
  endtask

  task automatic read_all;
    for (int a = 8'h3B; a <= 8'h41; a++) begin
      exp_q.push_back((a >= 8'h3C && a <= 8'h40) ? shadow[a - 8'h3C] : 8'h00);
      i_buck3_host_model.xfer(1'b0, a[7:0], 8'h00);
    end
  endtask

  task automatic check_outs;
    @(negedge clock);
    check(normal_code, shadow[0][5:0]);
    check(standby_code, shadow[1][5:0]);
    check(sleep_code, shadow[2][5:0]);
    check(range_high, range_exp);
    check({sleep_behaviour_select, switching_mode}, {shadow[3][5], shadow[3][3:0]});
    check(ctrl, {shadow[4][0], shadow[4][1], shadow[4][3:2], shadow[4][5:4], shadow[4][7:6]});
  endtask

  task automatic check_power;
    logic [5:0] c;
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      power_state <= p[1:0];
      @(negedge clock);
      c = (p == 1) ? shadow[1][5:0] : (p == 2) ? shadow[2][5:0] : shadow[0][5:0];
      check(active_code, c);
      check(active_mv, range_exp ? 12'h320 + 12'h032 * c : (c < 6'h09) ? 12'h000 : 12'h271 + 12'h019 * (c - 6'h09));
      check(active_reserved, range_exp ? (c > 6'h32) : (c < 6'h09));
      check(buck_enable, !(p == 2 && !shadow[3][5]));
    end
  endtask

  // ==========================================================
  // scenarios
  initial begin
    do_reset(1'b1);
    read_all;
    check_outs;
    $display("test reset values done");
    repeat (6) begin
      for (int a = 8'h3B; a <= 8'h41; a++) wr(a[7:0], 8'($random(seed)));
      for (int a = 8'h3D; a <= 8'h3F; a++) wr_rd(a[7:0], 8'($random(seed)));
      read_all;
      check_outs;
      check_power;
    end
    wr(8'h3C, 8'h0A);
    check_power;
    $display("test random access done");
    do_reset(1'b0);
    read_all;
    wr(8'h3C, 8'hC9);
    wr(8'h3D, 8'hFF);
    wr(8'h3E, 8'h4C);
    wr(8'h3F, 8'hF0);
    check_outs;
    check_power;
    wr(8'h3F, 8'h07);
    read_all;
    check_power;
    $display("test low range done");
    complete_run;
  end
endmodule // buck3_config_registers_tb

// *** buck3_host_model.sv ***
// buck3_host_model: host side of the register strobe port.
// assumes: one caller at a time; requests launched by non-blocking assignment on clock.
`timescale 1ns/100ps
module buck3_host_model (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // ==========================================================
  // one-cycle request, then idle lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // write then read of one address on consecutive edges; the read sees the new value
  task automatic xfer_wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clock);
    reg_wdata <= ~d;
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clock);
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
  endtask
endmodule // buck3_host_model

// *** buck3_pkg.sv ***
// buck3_pkg: constants, field layout and types for the buck3 configuration registers.
// assumes: 8-bit register addresses and data from the serial control port logic.
package buck3_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_NORMAL  = 8'h3C;
  localparam logic [7:0] ADDR_STANDBY = 8'h3D;
  localparam logic [7:0] ADDR_SLEEP   = 8'h3E;
  localparam logic [7:0] ADDR_MODE    = 8'h3F;
  localparam logic [7:0] ADDR_CONFIG  = 8'h40;

  // ==========================================================
  // field positions and reset values
  localparam int          CODE_W        = 6;
  localparam int          RANGE_BIT     = 6;
  localparam int          MODE_W        = 4;
  localparam int          SLEEP_PFM_BIT = 5;
  localparam int          ILIM_BIT      = 0;
  localparam int          FREQ_LSB      = 2;
  localparam int          PHASE_LSB     = 4;
  localparam int          RAMP_LSB      = 6;
  localparam logic [5:0]  CODE_RST      = 6'h00;
  localparam logic [3:0]  MODE_RST      = 4'h8;
  localparam logic [7:0]  CONFIG_RST    = 8'h00;
  localparam logic [7:0]  MODE_MASK     = 8'h2F;

  // ==========================================================
  // set point coding, in millivolts
  localparam logic [11:0] HI_BASE_MV  = 12'h320;
  localparam logic [11:0] HI_STEP_MV  = 12'h032;
  localparam logic [11:0] LO_BASE_MV  = 12'h271;
  localparam logic [11:0] LO_STEP_MV  = 12'h019;
  localparam logic [5:0]  LO_MIN_CODE = 6'h09;
  localparam logic [5:0]  HI_MAX_CODE = 6'h32;

  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SLEEP   = 2'b10
  } power_state_t;

  typedef struct packed {
    logic [5:0] normal_code;
    logic [5:0] standby_code;
    logic [5:0] sleep_code;
    logic [3:0] mode_sel;
    logic       sleep_pfm;
    logic [7:0] config_q;
    logic       range;
    logic [7:0] rdata;
  } state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       current_limit_low;
    logic       cfg_spare;
    logic [1:0] switching_frequency_select;
    logic [1:0] phase_clock_select;
    logic [1:0] ramp_speed_select;
  } buck_ctrl_t;

endpackage : buck3_pkg
